//--- design/csb_backoff.sv
// Contention-slot access rank, back-off counters and request/grant handshake.
// Function
// - Map link-frame priority to one of four access ranks.
// - Single-rank nodes still use top rank for medium plan frames.
// - Window starts after tone slots, else after claim slot, else slot start.
// - Keep wait, defer and stage counters for every access rank.
// - Zero wait count at window start sends in the first idle slot.
// - Decrement wait each quiet idle slot; send when it reaches zero.
// - Detected transmission: abandon slot, decrement defer, maybe decrement wait.
// - Defer at zero: raise or hold stage, reload defer and random wait.
// - Collision: raise stage below maximum, reload defer and random wait.
// - Reset and success: stage one, stage-one defer, random stage-one wait.
// - Gradual flag: success lowers stage by one, never below one.
// - Default defer 1,2,4,16 and window 8,16,32,64, software overridable.
// - Late frame contends only at or above winning rank, counting from then.
// - Handshake slots send a request frame before the message frame.
// - Addressed node answers a request with a grant after the request gap.
// - Message follows only a matching grant, one grant gap after it.
// - Request carries message destination and, for groups, a proxy member.
// - Grant withheld if unable to receive or medium busy.
// - Request and grant carry the whole sequence duration.
// - Any request or grant marks the slot used until it closes.
// - No grant within the full handshake time marks it not received.
// - Never use the handshake where the claim signal is required.
// - Rank tones: top both slots, two first, one second, zero neither.
`timescale 1ns/1ns
`include "csb_consts.svh"
module csb_backoff
  import csb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire csb_slot_ev_type slot_ev,
  input wire csb_rx_ev_type rx_ev,
  input wire logic frame_valid,
  input wire logic [2:0] frame_prio,
  input wire logic frame_plan,
  input wire logic [7:0] frame_dest,
  input wire logic [7:0] frame_proxy,
  input wire logic [15:0] frame_duration,
  input wire logic [1:0] win_rank,
  input wire logic can_receive,
  input wire logic medium_busy,
  output logic tx_start,
  output logic tx_is_rts,
  output logic [7:0] rts_dest,
  output logic [7:0] rts_proxy,
  output logic [15:0] tx_duration,
  output logic send_cts,
  output logic [7:0] cts_dest,
  output logic [15:0] cts_duration,
  output logic cts_missing,
  output logic slot_used,
  output logic rank_tone0,
  output logic rank_tone1,
  output logic contending
);
  logic [31:0] ctrl_reg, defer_reg, window_reg, gaps_reg;
  logic [31:0] status_w;
  csb_state_type state_reg;
  logic [15:0] lfsr_reg;
  logic init_reg;
  logic [1:0] rank_reg;
  logic [2:0] stage_reg [4];
  logic [7:0] defer_reg_a [4];
  logic [7:0] wait_reg [4];
  logic [1:0] pos_reg;
  logic cw_on_reg;
  logic [15:0] cnt_reg;
  logic [7:0] resp_cnt_reg;
  logic resp_pend_reg;
  logic [7:0] resp_src_reg;
  logic [15:0] resp_dur_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic [1:0] skip_w, tslot_w, rank_w;
  logic cw_go_w, use_rts_w, rank_ok_w, to_me_w;
  logic ev_idle_w, ev_busy_w, ev_coll_w, ev_succ_w, launch_w;
  logic [7:0] cur_wait_w;

  function automatic logic [7:0] lim(input logic [31:0] r, input logic [2:0] s);
    case (s)
      3'h2: lim = r[15:8];
      3'h3: lim = r[23:16];
      3'h4: lim = r[31:24];
      default: lim = r[7:0];
    endcase
  endfunction

  function automatic logic [7:0] draw(input logic [7:0] l, input logic [15:0] r);
    draw = (l == 8'h00) ? 8'h00 : r[7:0] % l;
  endfunction

  always_comb begin
    rank_w = 2'h0;
    case (ctrl_reg[`CSB_CTRL_NRANK])
      2'h3: case (frame_prio)
        3'h1, 3'h2: rank_w = 2'h0;
        3'h0, 3'h3: rank_w = 2'h1;
        3'h4, 3'h5: rank_w = 2'h2;
        default: rank_w = 2'h3;
      endcase
      2'h2: case (frame_prio)
        3'h1, 3'h2: rank_w = 2'h1;
        3'h6, 3'h7: rank_w = 2'h3;
        default: rank_w = 2'h2;
      endcase
      2'h1: rank_w = (frame_prio > 3'h3) ? 2'h3 : 2'h1;
      default: rank_w = 2'h1;
    endcase
    if (frame_plan) begin
      rank_w = 2'h3;
    end
  end

  assign skip_w = {1'b0, ctrl_reg[`CSB_CTRL_CLAIM]} + (ctrl_reg[`CSB_CTRL_TONE] ? 2'h2 : 2'h0);
  assign cw_go_w = (slot_ev.slot_start && skip_w == 2'h0) ||
                   (slot_ev.sub_end && !cw_on_reg && pos_reg + 2'h1 == skip_w);
  assign tslot_w = pos_reg - {1'b0, ctrl_reg[`CSB_CTRL_CLAIM]};
  assign use_rts_w = ctrl_reg[`CSB_CTRL_RTS] && !ctrl_reg[`CSB_CTRL_CLAIM];
  assign rank_ok_w = !ctrl_reg[`CSB_CTRL_TONE] || rank_w >= win_rank;
  assign to_me_w = rx_ev.dst == ctrl_reg[`CSB_CTRL_NODE] || rx_ev.proxy == ctrl_reg[`CSB_CTRL_NODE];
  assign cur_wait_w = wait_reg[rank_reg];
  assign ev_busy_w = state_reg == S_COUNT && cw_on_reg && slot_ev.sub_end && slot_ev.tx_det;
  assign ev_idle_w = state_reg == S_COUNT && cw_on_reg && slot_ev.sub_end && !slot_ev.tx_det &&
                     cur_wait_w != 8'h00;
  assign launch_w = state_reg == S_COUNT && !slot_used && !ev_busy_w &&
                    ((cw_go_w && cur_wait_w == 8'h00) ||
                     (ev_idle_w && cur_wait_w == 8'h01) ||
                     (cw_on_reg && slot_ev.sub_end && cur_wait_w == 8'h00));
  assign ev_coll_w = state_reg == S_TX && slot_ev.collision;
  assign ev_succ_w = state_reg == S_TX && slot_ev.success && !slot_ev.collision;
  assign status_w = {defer_reg_a[rank_reg], cur_wait_w, 5'h00, stage_reg[rank_reg], 2'h0, rank_reg,
                     1'b0, state_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_reg <= `CSB_LFSR_SEED;
      init_reg <= 1'b1;
    end else begin
      lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      init_reg <= 1'b0;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_rank
    logic hit;
    logic [2:0] st_up, st_dn;
    logic [7:0] dc_n;
    assign hit = rank_reg == 2'(g);
    assign st_up = (stage_reg[g] < `CSB_STAGE_MAX) ? stage_reg[g] + 3'h1 : stage_reg[g];
    assign st_dn = (ctrl_reg[`CSB_CTRL_GRAD] && stage_reg[g] > 3'h1) ? stage_reg[g] - 3'h1 : 3'h1;
    assign dc_n = defer_reg_a[g] - 8'h01;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stage_reg[g] <= 3'h1;
        defer_reg_a[g] <= 8'h01;
        wait_reg[g] <= 8'h00;
      end else if (init_reg) begin
        defer_reg_a[g] <= lim(defer_reg, 3'h1);
        wait_reg[g] <= draw(lim(window_reg, 3'h1), lfsr_reg + 16'(g));
      end else if (hit && ev_succ_w) begin
        stage_reg[g] <= st_dn;
        defer_reg_a[g] <= lim(defer_reg, st_dn);
        wait_reg[g] <= draw(lim(window_reg, st_dn), lfsr_reg);
      end else if (hit && (ev_coll_w || (ev_busy_w && dc_n == 8'h00))) begin
        stage_reg[g] <= st_up;
        defer_reg_a[g] <= lim(defer_reg, st_up);
        wait_reg[g] <= draw(lim(window_reg, st_up), lfsr_reg);
      end else if (hit && ev_busy_w) begin
        defer_reg_a[g] <= dc_n;
        if (wait_reg[g] != 8'h00) begin
          wait_reg[g] <= wait_reg[g] - 8'h01;
        end
      end else if (hit && ev_idle_w) begin
        wait_reg[g] <= wait_reg[g] - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg <= 2'h0;
      cw_on_reg <= 1'b0;
    end else if (slot_ev.slot_start) begin
      pos_reg <= 2'h0;
      cw_on_reg <= skip_w == 2'h0;
    end else if (slot_ev.slot_close || ev_coll_w || ev_succ_w) begin
      cw_on_reg <= 1'b0;
    end else if (slot_ev.sub_end && !cw_on_reg) begin
      pos_reg <= pos_reg + 2'h1;
      cw_on_reg <= cw_go_w;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_used <= 1'b0;
    end else if (rx_ev.rts_rx || rx_ev.cts_rx) begin
      slot_used <= 1'b1;
    end else if (slot_ev.slot_close) begin
      slot_used <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= S_IDLE;
      rank_reg <= 2'h0;
      cnt_reg <= 16'h0000;
      tx_start <= 1'b0;
      tx_is_rts <= 1'b0;
      rts_dest <= 8'h00;
      rts_proxy <= 8'h00;
      tx_duration <= 16'h0000;
      cts_missing <= 1'b0;
    end else begin
      tx_start <= 1'b0;
      cts_missing <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (frame_valid && !slot_used && (slot_ev.slot_start || (cw_on_reg && rank_ok_w))) begin
            rank_reg <= rank_w;
            state_reg <= S_COUNT;
          end
        end
        S_COUNT: begin
          if (ev_busy_w || slot_used || slot_ev.slot_close) begin
            state_reg <= S_HOLD;
          end else if (cw_go_w && ctrl_reg[`CSB_CTRL_TONE] && win_rank > rank_reg) begin
            state_reg <= S_HOLD;
          end else if (launch_w) begin
            tx_start <= 1'b1;
            tx_is_rts <= use_rts_w;
            rts_dest <= frame_dest;
            rts_proxy <= frame_proxy;
            tx_duration <= frame_duration;
            cnt_reg <= gaps_reg[`CSB_GAPS_CTSMAX];
            state_reg <= use_rts_w ? S_CTSW : S_TX;
          end
        end
        S_CTSW: begin
          if (rx_ev.cts_rx && rx_ev.dst == ctrl_reg[`CSB_CTRL_NODE]) begin
            cnt_reg <= {8'h00, gaps_reg[`CSB_GAPS_GRANT]};
            state_reg <= S_GAP;
          end else if (cnt_reg == 16'h0000) begin
            cts_missing <= 1'b1;
            state_reg <= S_HOLD;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        S_GAP: begin
          if (cnt_reg == 16'h0000) begin
            tx_start <= 1'b1;
            tx_is_rts <= 1'b0;
            state_reg <= S_TX;
          end else begin
            cnt_reg <= cnt_reg - 16'h0001;
          end
        end
        S_TX: begin
          if (slot_ev.success || slot_ev.collision) begin
            state_reg <= S_IDLE;
          end
        end
        S_HOLD: begin
          if (slot_ev.slot_close) begin
            state_reg <= S_IDLE;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      contending <= 1'b0;
      rank_tone0 <= 1'b0;
      rank_tone1 <= 1'b0;
    end else begin
      contending <= state_reg != S_IDLE && state_reg != S_HOLD;
      rank_tone0 <= state_reg == S_COUNT && ctrl_reg[`CSB_CTRL_TONE] && !cw_on_reg && !slot_ev.sub_end &&
                    pos_reg >= {1'b0, ctrl_reg[`CSB_CTRL_CLAIM]} && tslot_w == 2'h0 && rank_reg[1];
      rank_tone1 <= state_reg == S_COUNT && ctrl_reg[`CSB_CTRL_TONE] && !cw_on_reg && !slot_ev.sub_end &&
                    tslot_w == 2'h1 && rank_reg[0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_pend_reg <= 1'b0;
      resp_cnt_reg <= 8'h00;
      resp_src_reg <= 8'h00;
      resp_dur_reg <= 16'h0000;
      send_cts <= 1'b0;
      cts_dest <= 8'h00;
      cts_duration <= 16'h0000;
    end else begin
      send_cts <= 1'b0;
      if (rx_ev.rts_rx && to_me_w && can_receive && !medium_busy) begin
        resp_pend_reg <= 1'b1;
        resp_cnt_reg <= gaps_reg[`CSB_GAPS_REQ];
        resp_src_reg <= frame_dest;
        resp_dur_reg <= rx_ev.duration;
      end else if (resp_pend_reg && (medium_busy || !can_receive)) begin
        resp_pend_reg <= 1'b0;
      end else if (resp_pend_reg && resp_cnt_reg == 8'h00) begin
        resp_pend_reg <= 1'b0;
        send_cts <= 1'b1;
        cts_dest <= resp_src_reg;
        cts_duration <= resp_dur_reg;
      end else if (resp_pend_reg) begin
        resp_cnt_reg <= resp_cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      ctrl_reg <= `CSB_CTRL_RST;
      defer_reg <= `CSB_DEFER_RST;
      window_reg <= `CSB_WINDOW_RST;
      gaps_reg <= `CSB_GAPS_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            case (aw_addr_reg & 8'hFC)
              `CSB_CTRL_OFS: ctrl_reg[8*b+:8] <= w_data_reg[8*b+:8];
              `CSB_DEFER_OFS: defer_reg[8*b+:8] <= w_data_reg[8*b+:8];
              `CSB_WINDOW_OFS: window_reg[8*b+:8] <= w_data_reg[8*b+:8];
              `CSB_GAPS_OFS: gaps_reg[8*b+:8] <= w_data_reg[8*b+:8];
              default: ;
            endcase
          end
        end
        if ((aw_addr_reg & 8'hFC) > `CSB_GAPS_OFS) begin
          s_axi_bresp <= 2'h2;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr & 8'hFC)
        `CSB_CTRL_OFS: s_axi_rdata <= ctrl_reg;
        `CSB_DEFER_OFS: s_axi_rdata <= defer_reg;
        `CSB_WINDOW_OFS: s_axi_rdata <= window_reg;
        `CSB_GAPS_OFS: s_axi_rdata <= gaps_reg;
        `CSB_STATUS_OFS: s_axi_rdata <= status_w;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- design/csb_consts.svh
// Offsets, field positions, reset values and timing counts of the back-off block.
`ifndef CSB_CONSTS_SVH
`define CSB_CONSTS_SVH
`define CSB_CTRL_OFS 8'h00
`define CSB_DEFER_OFS 8'h04
`define CSB_WINDOW_OFS 8'h08
`define CSB_GAPS_OFS 8'h0C
`define CSB_STATUS_OFS 8'h10
`define CSB_CTRL_GRAD 0
`define CSB_CTRL_RTS 1
`define CSB_CTRL_CLAIM 2
`define CSB_CTRL_TONE 3
`define CSB_CTRL_NRANK 5:4
`define CSB_CTRL_NODE 15:8
`define CSB_GAPS_REQ 7:0
`define CSB_GAPS_GRANT 15:8
`define CSB_GAPS_CTSMAX 31:16
`define CSB_CTRL_RST 32'h0000_0038
`define CSB_DEFER_RST 32'h1004_0201
`define CSB_WINDOW_RST 32'h4020_1008
`define CSB_GAPS_RST 32'h0190_0A0A
`define CSB_STAGE_MAX 3'h4
`define CSB_LFSR_SEED 16'hACE1
`endif

//--- design/csb_pkg.sv
// Types shared by the back-off block and its bench.
package csb_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_COUNT = 3'b001,
    S_CTSW = 3'b010,
    S_GAP = 3'b011,
    S_TX = 3'b100,
    S_HOLD = 3'b101
  } csb_state_type;
  typedef struct packed {
    logic slot_start;
    logic sub_end;
    logic tx_det;
    logic collision;
    logic success;
    logic slot_close;
  } csb_slot_ev_type;
  typedef struct packed {
    logic rts_rx;
    logic cts_rx;
    logic [7:0] dst;
    logic [7:0] proxy;
    logic [15:0] duration;
  } csb_rx_ev_type;
endpackage

//--- sim/csb_checker.sv
// Assertions on the ports of the back-off block.
`timescale 1ns/1ns
module csb_checker
  import csb_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire csb_slot_ev_type slot_ev,
  input wire csb_rx_ev_type rx_ev,
  input wire logic [7:0] frame_dest,
  input wire logic [15:0] frame_duration,
  input wire logic can_receive,
  input wire logic medium_busy,
  input wire logic tx_start,
  input wire logic tx_is_rts,
  input wire logic [7:0] rts_dest,
  input wire logic [15:0] tx_duration,
  input wire logic send_cts,
  input wire logic cts_missing,
  input wire logic slot_used
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_tx_single: assert property (tx_start |=> !tx_start)
    else $error("launch pulse too long");
  a_rts_dest: assert property (tx_start && tx_is_rts |-> rts_dest == $past(frame_dest))
    else $error("request destination wrong");
  a_tx_span: assert property (tx_start |-> tx_duration == $past(frame_duration))
    else $error("sequence duration wrong");
  a_used_set: assert property (rx_ev.rts_rx || rx_ev.cts_rx |=> slot_used)
    else $error("slot not marked used");
  a_used_hold: assert property (slot_used && !slot_ev.slot_close |=> slot_used)
    else $error("slot used cleared early");
  a_abandon_slot: assert property (slot_ev.sub_end && slot_ev.tx_det |=> !tx_start)
    else $error("sent after detected transmission");
  a_cts_allowed: assert property (send_cts |-> $past(can_receive) && !$past(medium_busy))
    else $error("grant sent while refused");
  a_cts_gap: assert property (rx_ev.rts_rx |=> !send_cts [*2])
    else $error("grant sent too soon");
  a_cts_wait: assert property (tx_start && tx_is_rts |=> !cts_missing [*8])
    else $error("grant declared missing too soon");
endmodule
bind csb_backoff csb_checker chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .slot_ev(slot_ev), .rx_ev(rx_ev),
  .frame_dest(frame_dest), .frame_duration(frame_duration), .can_receive(can_receive),
  .medium_busy(medium_busy), .tx_start(tx_start), .tx_is_rts(tx_is_rts), .rts_dest(rts_dest),
  .tx_duration(tx_duration), .send_cts(send_cts), .cts_missing(cts_missing), .slot_used(slot_used));

//--- sim/csb_peer.sv
// Model of the other nodes on the medium: slot grid events and handshake frames.
`timescale 1ns/1ns
module csb_peer
  import csb_pkg::*;
(
  input wire logic aclk,
  output csb_slot_ev_type slot_ev,
  output csb_rx_ev_type rx_ev
);
  initial begin
    slot_ev = '0;
    rx_ev = '0;
  end
  // Pulses one slot event, then keeps the grid quiet for three cycles.
  task automatic ev(input csb_slot_ev_type e);
    slot_ev <= e;
    @(posedge aclk);
    slot_ev <= '0;
    repeat (3) @(posedge aclk);
  endtask
  // Sends a request or grant; the fields show no stale value afterwards.
  task automatic frame(input logic rts, input logic [7:0] dst, input logic [15:0] dur);
    rx_ev <= {rts, !rts, dst, ~dst, dur};
    @(posedge aclk);
    rx_ev <= {2'h0, ~dst, dst, ~dur};
    repeat (3) @(posedge aclk);
  endtask
endmodule

//--- sim/contention_slot_backoff_rts_tb.sv
// Self-checking bench of the back-off block with its medium peer.
`timescale 1ns/1ns
`include "csb_consts.svh"
module contention_slot_backoff_rts_tb
  import csb_pkg::*;
;
  logic aclk = 1'h0, aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, frame_dest = 8'h00, frame_proxy = 8'h00;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, d, rnd = 32'h5C7B;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic frame_valid = 1'h0, frame_plan = 1'h0, can_receive = 1'h1, medium_busy = 1'h0, last_rts = 1'h0;
  logic [2:0] frame_prio = 3'h7;
  logic [15:0] frame_duration = 16'h0, last_dur, last_cdur;
  logic [1:0] win_rank = 2'h0, s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_start, tx_is_rts;
  logic send_cts, cts_missing, slot_used, rank_tone0, rank_tone1, contending;
  logic [31:0] s_axi_rdata;
  logic [7:0] rts_dest, rts_proxy, cts_dest, last_dest;
  logic [15:0] tx_duration, cts_duration;
  csb_slot_ev_type slot_ev;
  csb_rx_ev_type rx_ev;
  int err_total = 0, n_tests = 0, cyc = 0, n_tx = 0, n_cts = 0, n_miss = 0, tx_cyc, cts_cyc, rts_cyc, gnt_cyc, t0;
  always #20 aclk = ~aclk;
  csb_peer peer_u (.aclk(aclk), .slot_ev(slot_ev), .rx_ev(rx_ev));
  csb_backoff dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .slot_ev(slot_ev), .rx_ev(rx_ev), .frame_valid(frame_valid), .frame_prio(frame_prio), .frame_plan(frame_plan),
    .frame_dest(frame_dest), .frame_proxy(frame_proxy), .frame_duration(frame_duration), .win_rank(win_rank),
    .can_receive(can_receive), .medium_busy(medium_busy), .tx_start(tx_start), .tx_is_rts(tx_is_rts),
    .rts_dest(rts_dest), .rts_proxy(rts_proxy), .tx_duration(tx_duration), .send_cts(send_cts),
    .cts_dest(cts_dest), .cts_duration(cts_duration), .cts_missing(cts_missing), .slot_used(slot_used),
    .rank_tone0(rank_tone0), .rank_tone1(rank_tone1), .contending(contending));
  // Records launches and grants with their cycle numbers and counts missing-grant pulses.
  always @(posedge aclk) begin
    cyc++;
    if (tx_start) begin
      n_tx++;
      tx_cyc = cyc;
      last_rts = tx_is_rts;
      last_dest = rts_dest;
      last_dur = tx_duration;
    end
    if (send_cts) begin
      n_cts++;
      cts_cyc = cyc;
      last_cdur = cts_duration;
    end
    n_miss += cts_missing;
    if (rx_ev.rts_rx) rts_cyc = cyc;
    if (rx_ev.cts_rx) gnt_cyc = cyc;
  end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int k);
    if (k >= 50) begin
      err_total++;
      $display("CHECK FAILED t=%0t wait bound %h", $time, k);
      complete_run();
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    logic ta, tw;
    k = 0;
    ta = 1'h0;
    tw = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      s_axi_awvalid <= !ta;
      s_axi_wvalid <= !tw;
    end while (!(ta && tw) && k < 50);
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_bvalid && k < 50);
    rs = s_axi_bresp;
    s_axi_bready <= 1'h0;
    @(posedge aclk);
    tmo(k);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_arready && k < 50);
    s_axi_arvalid <= 1'h0;
    do begin
      @(posedge aclk);
      k++;
    end while (!s_axi_rvalid && k < 50);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
    tmo(k);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    axi_wr(a, v, r);
    chk(r, 2'h0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] v);
    axi_rd(a, d, r);
    chk(d, v);
    chk(r, 2'h0);
  endtask
  // One contention slot: pre plain sub-slots, then one sub-slot that is busy when det is set, then an outcome event.
  task automatic step(input int pre, input logic det, input logic [5:0] outc, input logic [2:0] es,
    input logic [7:0] ed);
    rnd = nxt(rnd);
    frame_dest <= rnd[7:0];
    frame_duration <= rnd[23:8];
    frame_proxy <= rnd[31:24];
    frame_valid <= 1'h1;
    t0 = n_tx;
    peer_u.ev(6'h20);
    repeat (pre) peer_u.ev(6'h10);
    peer_u.ev({2'h1, det, 3'h0});
    chk(n_tx - t0, !det);
    if (outc != 6'h00) peer_u.ev(outc);
    if (es != 3'h0) begin
      axi_rd(`CSB_STATUS_OFS, d, r);
      chk(d[10:8], es);
      if (ed != 8'hFF) chk(d[31:24], ed);
    end
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rd_chk(`CSB_CTRL_OFS, `CSB_CTRL_RST);
    rd_chk(`CSB_DEFER_OFS, {8'h10, 8'h04, 8'h02, 8'h01});
    rd_chk(`CSB_WINDOW_OFS, {8'h40, 8'h20, 8'h10, 8'h08});
    rd_chk(`CSB_GAPS_OFS, `CSB_GAPS_RST);
    axi_rd(8'h14, d, r);
    chk(r, 2'h2);
    axi_wr(`CSB_STATUS_OFS, 32'h0, r);
    chk(r, 2'h2);
    wr(`CSB_GAPS_OFS, 32'h0014_0403);
    rd_chk(`CSB_GAPS_OFS, 32'h0014_0403);
    wr(`CSB_CTRL_OFS, 32'h0000_2130);
    $display("test registers done");
    step(8, 1'h0, 6'h04, 3'h2, 8'h02);
    wr(`CSB_WINDOW_OFS, 32'h0101_0101);
    step(0, 1'h1, 6'h01, 3'h2, 8'h01);
    step(0, 1'h1, 6'h01, 3'h3, 8'h04);
    step(0, 1'h0, 6'h04, 3'h4, 8'h10);
    step(0, 1'h0, 6'h04, 3'h4, 8'h10);
    step(0, 1'h0, 6'h02, 3'h1, 8'h01);
    wr(`CSB_CTRL_OFS, 32'h0000_2131);
    step(0, 1'h0, 6'h04, 3'h2, 8'h02);
    step(0, 1'h0, 6'h04, 3'h3, 8'h04);
    step(0, 1'h0, 6'h02, 3'h2, 8'hFF);
    step(0, 1'h0, 6'h02, 3'h1, 8'hFF);
    step(0, 1'h0, 6'h02, 3'h1, 8'hFF);
    $display("test backoff done");
    wr(`CSB_CTRL_OFS, 32'h0000_2132);
    step(0, 1'h0, 6'h00, 3'h0, 8'h00);
    chk(last_rts, 1'h1);
    chk(last_dest, frame_dest);
    chk(last_dur, frame_duration);
    peer_u.frame(1'h0, 8'h21, 16'h0100);
    repeat (6) @(posedge aclk);
    chk(n_tx - t0, 2);
    chk(last_rts, 1'h0);
    chk(tx_cyc - gnt_cyc, 6);
    peer_u.ev(6'h03);
    step(0, 1'h0, 6'h00, 3'h0, 8'h00);
    repeat (30) @(posedge aclk);
    chk(n_miss, 1);
    chk(n_tx - t0, 1);
    peer_u.ev(6'h01);
    wr(`CSB_CTRL_OFS, 32'h0000_2136);
    step(1, 1'h0, 6'h02, 3'h1, 8'h01);
    chk(last_rts, 1'h0);
    frame_valid <= 1'h0;
    $display("test handshake done");
    for (int i = 0; i < 4; i++) begin
      medium_busy <= (i == 1);
      can_receive <= (i != 2);
      t0 = n_cts;
      rnd = nxt(rnd);
      peer_u.frame(1'h1, (i == 3) ? 8'hDE : 8'h21, rnd[15:0]);
      repeat (4) @(posedge aclk);
      chk(n_cts - t0, (i == 0 || i == 3));
      if (i == 0) chk(cts_cyc - rts_cyc, 5);
      if (i == 0) chk(last_cdur, rnd[15:0]);
    end
    can_receive <= 1'h1;
    medium_busy <= 1'h0;
    chk(slot_used, 1'h1);
    peer_u.ev(6'h01);
    chk(slot_used, 1'h0);
    $display("test responder done");
    for (int i = 0; i < 3; i++) begin
      frame_plan <= (i == 0);
      frame_prio <= (i == 2) ? 3'h4 : 3'h7;
      wr(`CSB_CTRL_OFS, (i < 2) ? 32'h0000_2100 : 32'h0000_2138);
      step(8, 1'h0, 6'h00, 3'h0, 8'h00);
      axi_rd(`CSB_STATUS_OFS, d, r);
      chk(d[5:4], (i == 0) ? 2'h3 : 2'(i));
      peer_u.ev(6'h02);
    end
    $display("test ranks done");
    complete_run();
  end
endmodule
